// *** pqs_cmd.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Power query is decoded from either of two opcodes.
// - Legacy mode power query reports whether spindle is up and media ready.
// - Legacy mode idle returns FFh in sector count, never 80h.
// - Legacy mode standby returns zero in sector count.
// - Extended mode returns 81h/82h/83h idle, 01h/00h standby codes.
// - Stream configure has its own opcode, one stream per command.
// - Adding a valid identifier overwrites its stored parameters.
// - An aborted configure leaves stored parameters untouched.
// - Configure aborts when streaming support is absent.
// - Removing an unconfigured identifier aborts.
// - Default limit is feature previous times identify time unit.
// - Stored default limit applies when later limit request is zero.
// - Limit is timed from opcode write to completion interrupt.
// - Default limit below the device minimum is raised to the minimum.
// - Device/head bit 4 is ignored for every command.
// - Status and error are final when completion is signalled.
module pqs_cmd #(
   parameter int LIM_W = 32,              // Limit width in microseconds
   parameter int NSTR = pqs_pkg::NUM_STREAMS
) (
   input wire logic clk_i,                // Clock, 250 MHz
   input wire logic rst_n_i,              // Sync reset, active low
   input wire logic cmd_wr_i,             // Host wrote command register
   input wire logic [7:0] cmd_i,          // Command opcode
   input wire logic [7:0] feat_cur_i,     // Feature current
   input wire logic [7:0] feat_prev_i,    // Feature previous
   input wire logic [7:0] count_cur_i,    // Sector count current
   input wire logic [7:0] count_prev_i,   // Sector count previous
   input wire logic [7:0] dev_head_i,     // Device/head, bit 4 ignored
   input wire logic [15:0] time_unit_i,   // Identify words 99:98
   input wire logic [LIM_W-1:0] min_lim_i, // Device minimum limit, us
   input wire logic stream_sup_i,         // Streaming feature present
   input wire logic epc_en_i,             // Extended power conditions on
   input wire logic [2:0] pwr_cond_i,     // Current power condition
   input wire logic spun_up_i,            // Spindle up, media ready
   input wire logic lim_req_i,            // Streaming command asks limit
   input wire logic [2:0] lim_id_i,       // Its stream identifier
   input wire logic [LIM_W-1:0] lim_val_i, // Its requested limit
   output logic [7:0] count_o,            // Returned sector count
   output logic [7:0] command_error_flags_o,  // Error register
   output logic [7:0] command_status_flags_o, // Status register
   output logic done_o,                   // Completion interrupt pulse
   output logic [LIM_W-1:0] lim_o,        // Effective limit, us
   output logic [NSTR-1:0] valid_o        // Configured streams
);
   // Eight slots are hard wired and the limit product needs 24 bits
   if (NSTR != 8 || LIM_W < 24) begin : g_bad_param
      $error("pqs_cmd: unsupported parameters");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} pqs_st_t;
   typedef struct packed {
      pqs_st_t st;
      logic [7:0] count;
      logic [7:0] err;
      logic [7:0] sts;
      logic done;
      logic [LIM_W-1:0] lim;
      logic [NSTR-1:0] valid;
   } pqs_state_t;
   pqs_state_t s_q, s_d;

   logic [NSTR-1:0] load, clear, slot_valid, slot_dir;
   logic [LIM_W-1:0] slot_lim [NSTR];
   logic [15:0] slot_alloc [NSTR];
   logic [LIM_W-1:0] raw_lim, new_lim;
   logic [2:0] sid;
   logic add_req, is_pwr, is_cfg, cfg_abort;

   // Device/head is never looked at, so bit 4 cannot change decoding
   assign sid = feat_cur_i[2:0];
   assign add_req = feat_cur_i[pqs_pkg::FEAT_ADD_BIT];
   assign is_pwr = (cmd_i == pqs_pkg::OP_PWR_QUERY_A) || (cmd_i == pqs_pkg::OP_PWR_QUERY_B);
   assign is_cfg = (cmd_i == pqs_pkg::OP_STREAM_CFG);
   assign cfg_abort = !stream_sup_i || (!add_req && !slot_valid[sid]);
   // Operands widened first so the 24-bit product is never cut; then clamp
   assign raw_lim = LIM_W'(feat_prev_i) * LIM_W'(time_unit_i);
   assign new_lim = (raw_lim < min_lim_i) ? min_lim_i : raw_lim;

   // ----------------------------------------------------------------
   // Stream slots
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSTR; g++) begin : g_slot
         // Writes only on a non-aborted configure, so aborts keep old data
         assign load[g] = (s_q.st == ST_EXEC) && is_cfg && !cfg_abort && add_req && (sid == g);
         assign clear[g] = (s_q.st == ST_EXEC) && is_cfg && !cfg_abort && !add_req && (sid == g);
         pqs_stream_slot #(.LIM_W(LIM_W)) u_slot (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .load_i(load[g]),
            .clear_i(clear[g]),
            .dir_i(feat_cur_i[pqs_pkg::FEAT_DIR_BIT]),
            .lim_i(new_lim),
            .alloc_i({count_prev_i, count_cur_i}),
            .valid_o(slot_valid[g]),
            .dir_o(slot_dir[g]),
            .lim_o(slot_lim[g]),
            .alloc_o(slot_alloc[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   // Inputs are held by the host from the opcode write until done
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.valid = slot_valid;
      // Effective limit: zero request falls back to stored default
      if (lim_req_i) begin
         s_d.lim = (lim_val_i == '0) ? slot_lim[lim_id_i] : lim_val_i;
      end
      unique case (s_q.st)
         ST_IDLE: begin
            if (cmd_wr_i) begin
               s_d.st = ST_EXEC;
               s_d.sts[pqs_pkg::STS_BUSY_BIT] = 1'b1;
            end
         end
         ST_EXEC: begin
            s_d.st = ST_DONE;
            s_d.err = pqs_pkg::ERR_RESET;
            s_d.sts = pqs_pkg::STS_RESET;
            if (is_pwr) begin
               if (!epc_en_i) begin
                  s_d.count = spun_up_i ? pqs_pkg::PM_IDLE_LEGACY
                                        : pqs_pkg::PM_STANDBY_LEGACY;
               end else begin
                  unique case (pwr_cond_i)
                     pqs_pkg::PC_IDLE_A: s_d.count = pqs_pkg::PM_IDLE_A;
                     pqs_pkg::PC_IDLE_B: s_d.count = pqs_pkg::PM_IDLE_B;
                     pqs_pkg::PC_IDLE_C: s_d.count = pqs_pkg::PM_IDLE_C;
                     pqs_pkg::PC_STANDBY_Y: s_d.count = pqs_pkg::PM_STANDBY_Y;
                     default: s_d.count = pqs_pkg::PM_STANDBY_Z;
                  endcase
               end
            end else if (!is_cfg || cfg_abort) begin
               // Unknown opcodes abort as well
               s_d.err[pqs_pkg::ERR_ABORT_BIT] = 1'b1;
               s_d.sts[pqs_pkg::STS_ERR_BIT] = 1'b1;
            end
         end
         ST_DONE: begin
            // Registers are final one cycle before the pulse
            s_d.st = ST_IDLE;
            s_d.done = 1'b1;
         end
      endcase
   end

   // State register, sync reset to the idle values
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '{st: ST_IDLE, count: 8'h00, err: pqs_pkg::ERR_RESET,
                  sts: pqs_pkg::STS_RESET, done: 1'b0, lim: '0, valid: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign count_o = s_q.count;
   assign command_error_flags_o = s_q.err;
   assign command_status_flags_o = s_q.sts;
   assign done_o = s_q.done;
   assign lim_o = s_q.lim;
   assign valid_o = s_q.valid;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_idle_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_pwr && !epc_en_i && spun_up_i) |=> count_o == 8'hff)
      else $error("idle code wrong");
   a_standby_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_pwr && !epc_en_i && !spun_up_i) |=> count_o == 8'h00)
      else $error("standby code wrong");
   a_ext_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_pwr && epc_en_i && pwr_cond_i == 3'h0) |=> count_o == 8'h81)
      else $error("idle_a code wrong");
   a_abort_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_cfg && cfg_abort) |=> command_error_flags_o[2]
      && command_status_flags_o[0] && !command_status_flags_o[7] ##1 done_o)
      else $error("abort flags wrong");
   a_remove_abort: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_cfg && stream_sup_i && !add_req && !slot_valid[sid])
      |=> command_error_flags_o[2])
      else $error("bad removal not aborted");
   // Slot limit is checked one cycle after the aborted configure; valid_o lags the slots by a cycle, so a wrong clear is missed
   a_keep_params: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_cfg && cfg_abort)
      |=> $stable(valid_o) && $stable(slot_lim[sid]))
      else $error("abort changed streams");
   a_add_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_EXEC && is_cfg && !cfg_abort && add_req) |-> ##2 valid_o[$past(sid, 2)])
      else $error("add not stored");
   a_min_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (load != '0) |=> slot_lim[$past(sid)] >= $past(min_lim_i))
      else $error("limit below minimum");
   a_dir_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (load != '0) |=> slot_dir[$past(sid)] == $past(feat_cur_i[pqs_pkg::FEAT_DIR_BIT]))
      else $error("direction not stored");
   a_alloc_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (load != '0) |=> slot_alloc[$past(sid)] == $past({count_prev_i, count_cur_i}))
      else $error("allocation unit not stored");
   a_done_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_IDLE && cmd_wr_i) |-> ##3 done_o)
      else $error("completion late");
   // Main scenarios
   c_pwr: cover property (@(posedge clk_i) s_q.st == ST_EXEC && is_pwr);
   c_add: cover property (@(posedge clk_i) load != '0);
   c_remove: cover property (@(posedge clk_i) clear != '0);
   c_abort: cover property (@(posedge clk_i) s_q.st == ST_EXEC && is_cfg && cfg_abort);
endmodule // pqs_cmd

// *** pqs_pkg.sv ***
package pqs_pkg;
   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_PWR_QUERY_A = 8'he5;
   localparam logic [7:0] OP_PWR_QUERY_B = 8'h98;
   localparam logic [7:0] OP_STREAM_CFG = 8'h51;
   // ----------------------------------------------------------------
   // Power mode codes
   // ----------------------------------------------------------------
   localparam logic [7:0] PM_IDLE_LEGACY = 8'hff;
   localparam logic [7:0] PM_STANDBY_LEGACY = 8'h00;
   localparam logic [7:0] PM_IDLE_A = 8'h81;
   localparam logic [7:0] PM_IDLE_B = 8'h82;
   localparam logic [7:0] PM_IDLE_C = 8'h83;
   localparam logic [7:0] PM_STANDBY_Y = 8'h01;
   localparam logic [7:0] PM_STANDBY_Z = 8'h00;
   // Power condition input encoding
   localparam logic [2:0] PC_IDLE_A = 3'h0;
   localparam logic [2:0] PC_IDLE_B = 3'h1;
   localparam logic [2:0] PC_IDLE_C = 3'h2;
   localparam logic [2:0] PC_STANDBY_Y = 3'h3;
   localparam logic [2:0] PC_STANDBY_Z = 3'h4;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FEAT_ADD_BIT = 7;
   localparam int FEAT_DIR_BIT = 6;
   localparam int ERR_ABORT_BIT = 2;
   localparam int STS_BUSY_BIT = 7;
   localparam int STS_READY_BIT = 6;
   localparam int STS_SEEK_BIT = 4;
   localparam int STS_ERR_BIT = 0;
   // ----------------------------------------------------------------
   // Reset values and stream count
   // ----------------------------------------------------------------
   localparam logic [7:0] ERR_RESET = 8'h00;
   localparam logic [7:0] STS_RESET = 8'h50;
   localparam int NUM_STREAMS = 8;
endpackage

// *** pqs_stream_slot.sv ***
`timescale 1ns/1ps
// One stream parameter slot: holds direction, limit and unit size
module pqs_stream_slot #(
   parameter int LIM_W = 32
) (
   input wire logic clk_i,            // Clock
   input wire logic rst_n_i,          // Sync reset, active low
   input wire logic load_i,           // Store new parameters
   input wire logic clear_i,          // Remove the stream
   input wire logic dir_i,            // 1 = write stream
   input wire logic [LIM_W-1:0] lim_i, // Completion limit, us
   input wire logic [15:0] alloc_i,   // Allocation unit, sectors
   output logic valid_o,              // Slot in use
   output logic dir_o,                // Stored direction
   output logic [LIM_W-1:0] lim_o,    // Stored limit
   output logic [15:0] alloc_o        // Stored allocation unit
);
   typedef struct packed {
      logic valid;
      logic dir;
      logic [LIM_W-1:0] lim;
      logic [15:0] alloc;
   } pqs_slot_t;
   pqs_slot_t slot_q, slot_d;

   // Load wins over clear; the main block never asserts both
   always_comb begin
      slot_d = slot_q;
      if (load_i) begin
         slot_d.valid = 1'b1;
         slot_d.dir = dir_i;
         slot_d.lim = lim_i;
         slot_d.alloc = alloc_i;
      end else if (clear_i) begin
         slot_d.valid = 1'b0;
      end
   end

   // Sync reset empties the slot, so no stream survives a reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         slot_q <= '0;
      end else begin
         slot_q <= slot_d;
      end
   end

   assign valid_o = slot_q.valid;
   assign dir_o = slot_q.dir;
   assign lim_o = slot_q.lim;
   assign alloc_o = slot_q.alloc;
endmodule // pqs_stream_slot

// *** pqs_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the command block
// ----------------------------------------------------------------
module pqs_host_model (
   input wire logic clk_i,          // Clock
   input wire logic done_i,         // Completion pulse
   input wire logic [7:0] sts_i,    // Status register
   input wire logic [31:0] lim_i,   // Effective limit
   output logic cmd_wr_o,           // Command write strobe
   output logic [7:0] cmd_o,        // Opcode
   output logic [7:0] fc_o,         // Feature current
   output logic [7:0] fp_o,         // Feature previous
   output logic [15:0] al_o,        // Sector count previous:current
   output logic [7:0] dh_o,         // Device/head
   output logic lim_req_o,          // Limit request
   output logic [2:0] lim_id_o,     // Limit stream identifier
   output logic [31:0] lim_val_o,   // Requested limit
   output logic tmo_o               // A wait ran out
);
   // Idle host drives zeros before the first command
   initial {cmd_wr_o, cmd_o, fc_o, fp_o, al_o, dh_o, lim_req_o, lim_id_o, lim_val_o, tmo_o} = '0;

   // Held until completion; released lines show inverted data so stale values never match
   task automatic issue(input logic [7:0] op, input logic [7:0] fc, input logic [7:0] fp,
                        input logic [7:0] dh, output logic busy_bit);
      int n;
      @(negedge clk_i);
      cmd_o <= op;
      fc_o <= fc;
      fp_o <= fp;
      al_o <= {fp, fc};
      dh_o <= dh;
      cmd_wr_o <= 1'b1;
      busy_bit = 1'b0;
      repeat (2) begin
         @(negedge clk_i);
         busy_bit = busy_bit | sts_i[pqs_pkg::STS_BUSY_BIT];
      end
      n = 0;
      while (done_i !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 20) tmo_o <= 1'b1;
      cmd_wr_o <= 1'b0;
      {cmd_o, fc_o, fp_o, al_o, dh_o} <= ~{op, fc, fp, fp, fc, dh};
   endtask

   // Streaming command asking for its limit, one cycle long
   task automatic ask(input logic [2:0] id, input logic [31:0] v, output logic [31:0] lim);
      @(negedge clk_i);
      lim_req_o <= 1'b1;
      lim_id_o <= id;
      lim_val_o <= v;
      @(negedge clk_i);
      lim = lim_i;
      lim_req_o <= 1'b0;
      {lim_id_o, lim_val_o} <= ~{id, v};
   endtask
endmodule // pqs_host_model

// *** tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for power query and stream configure
// ----------------------------------------------------------------
module tb;
   // env = {extended on, spun up, streaming present, power condition}
   typedef struct packed {
      logic [7:0] op, fc, fp;
      logic [5:0] env;
      logic [7:0] cnt, err, sts, vld;
   } pqs_row_t;
   localparam pqs_row_t ROWS [14] = '{
      '{8'he5, 8'h00, 8'h00, 6'h18, 8'hff, 8'h00, 8'h50, 8'h00},
      '{8'h51, 8'hc3, 8'h02, 6'h18, 8'hff, 8'h00, 8'h50, 8'h08},
      '{8'h51, 8'h05, 8'h00, 6'h18, 8'hff, 8'h04, 8'h51, 8'h08},
      '{8'h51, 8'h80, 8'h00, 6'h10, 8'hff, 8'h04, 8'h51, 8'h08},
      '{8'h27, 8'h00, 8'h00, 6'h18, 8'hff, 8'h04, 8'h51, 8'h08},
      '{8'h51, 8'h03, 8'h00, 6'h18, 8'hff, 8'h00, 8'h50, 8'h00},
      '{8'h51, 8'h87, 8'h00, 6'h18, 8'hff, 8'h00, 8'h50, 8'h80},
      '{8'h98, 8'h00, 8'h00, 6'h08, 8'h00, 8'h00, 8'h50, 8'h80},
      '{8'he5, 8'h00, 8'h00, 6'h38, 8'h81, 8'h00, 8'h50, 8'h80},
      '{8'h98, 8'h00, 8'h00, 6'h39, 8'h82, 8'h00, 8'h50, 8'h80},
      '{8'he5, 8'h00, 8'h00, 6'h3a, 8'h83, 8'h00, 8'h50, 8'h80},
      '{8'h98, 8'h00, 8'h00, 6'h3b, 8'h01, 8'h00, 8'h50, 8'h80},
      '{8'he5, 8'h00, 8'h00, 6'h3c, 8'h00, 8'h00, 8'h50, 8'h80},
      '{8'h98, 8'h00, 8'h00, 6'h18, 8'hff, 8'h00, 8'h50, 8'h80}};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic epc, spun, sup, wr, lreq, tmo, busy_bit, done;
   logic [2:0] pc, lid;
   logic [15:0] tu, al;
   logic [31:0] mn, lval, lim;
   logic [7:0] op, fc, fp, dh, cnt, err, sts, vld;
   int error_cnt = 0;
   int checks_done = 0;

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   pqs_cmd pqs_cmd_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_wr_i(wr), .cmd_i(op), .feat_cur_i(fc),
      .feat_prev_i(fp), .count_cur_i(al[7:0]), .count_prev_i(al[15:8]), .dev_head_i(dh),
      .time_unit_i(tu), .min_lim_i(mn), .stream_sup_i(sup), .epc_en_i(epc),
      .pwr_cond_i(pc), .spun_up_i(spun), .lim_req_i(lreq), .lim_id_i(lid),
      .lim_val_i(lval), .count_o(cnt), .command_error_flags_o(err),
      .command_status_flags_o(sts), .done_o(done), .lim_o(lim), .valid_o(vld));

   pqs_host_model pqs_host_model_inst (
      .clk_i(clk_i), .done_i(done), .sts_i(sts), .lim_i(lim), .cmd_wr_o(wr), .cmd_o(op),
      .fc_o(fc), .fp_o(fp), .al_o(al), .dh_o(dh), .lim_req_o(lreq), .lim_id_o(lid),
      .lim_val_o(lval), .tmo_o(tmo));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("mismatches=%0d comparisons=%0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One command; a hang ends the run only at the next command's check, since tmo is set nonblocking
   task automatic cfg(input logic [7:0] o, input logic [7:0] f, input logic [7:0] p,
                      input logic [7:0] d);
      pqs_host_model_inst.issue(o, f, p, d, busy_bit);
      chk({31'h0, busy_bit}, 32'h1);
      if (tmo !== 1'b0) begin
         error_cnt++;
         print_verdict();
      end
   endtask

   task automatic lchk(input logic [31:0] v, input logic [31:0] exp);
      logic [31:0] l;
      pqs_host_model_inst.ask(3'h2, v, l);
      chk(l, exp);
   endtask

   // Reset values, the table, then limit handling and a second reset
   initial begin
      {epc, spun, sup, pc} = 6'h18;
      tu = 16'h000a;
      mn = 32'h14;
      repeat (6) @(negedge clk_i);
      chk({cnt, err, sts, vld}, {8'h00, pqs_pkg::ERR_RESET, pqs_pkg::STS_RESET, 8'h00});
      chk({lim[23:0], 7'h0, done}, 32'h0);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         {epc, spun, sup, pc} <= ROWS[i].env;
         cfg(ROWS[i].op, ROWS[i].fc, ROWS[i].fp, (i % 2) ? 8'hb0 : 8'ha0);
         chk(cnt, ROWS[i].cnt);
         chk({err, sts}, {ROWS[i].err, ROWS[i].sts});
         chk(vld, ROWS[i].vld);
      end
      // Five times ten, later a limit below the minimum, then an aborted overwrite
      cfg(8'h51, 8'h82, 8'h05, 8'ha0);
      lchk(32'h0, 32'h32);
      lchk(32'h7, 32'h7);
      cfg(8'h51, 8'hc2, 8'h01, 8'hb0);
      lchk(32'h0, 32'h14);
      sup <= 1'b0;
      cfg(8'h51, 8'h82, 8'h09, 8'ha0);
      chk({err, sts}, 16'h0451);
      lchk(32'h0, 32'h14);
      rst_n_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk({vld, sts, cnt, err}, {8'h00, pqs_pkg::STS_RESET, 8'h00, pqs_pkg::ERR_RESET});
      chk({lim[23:0], 7'h0, done}, 32'h0);
      // Reset must empty every slot: removal aborts, stored limit reads zero
      sup <= 1'b1;
      rst_n_i <= 1'b1;
      cfg(8'h51, 8'h02, 8'h00, 8'ha0);
      chk({err, sts}, 16'h0451);
      chk(vld, 8'h00);
      lchk(32'h0, 32'h0);
      print_verdict();
   end
endmodule // tb
